// ---- dv/ext_equipment.sv ----
// External equipment model: drives the opto-isolated inputs and watches the output transistors
`timescale 1ns/1ps
`default_nettype none
module ext_equipment (
    input wire logic [1:0] level,
    input wire logic [3:0] out_ctrl,
    output wire logic [1:0] in_pin,
    output wire logic [3:0] conducting
);
    // ==========================================
    // Opto path with a delay unrelated to the camera clock
    assign #7 in_pin = level;
    // A control bit of one makes the transistor conduct
    assign conducting = out_ctrl;
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Testbench for the camera I/O line routing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ==========================================
    // Signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0; // Active low reset
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, hw_trig, user_in, in_pin;
    logic [31:0] rdata;
    logic [1:0] level = 2'h0; // Levels the external equipment applies
    logic acq = 1'b0, frame = 1'b0, expo = 1'b0;
    logic [3:0] tmr = 4'h0, out_ctrl, cond;
    // Expected configuration of each output, out1 first
    logic [2:0] src_cfg [4] = '{io_line_pkg::SRC_EXPOSURE, io_line_pkg::SRC_FRAME_WAIT,
                                io_line_pkg::SRC_TIMER, io_line_pkg::SRC_USER};
    logic [3:0] inv_cfg = 4'h0, uval = 4'h0;
    logic [31:0] d;
    logic [1:0] st;
    int miscompares = 0, compares = 0;
    int i, o, s, v, m, lv;
    // ==========================================
    // Design and external equipment
    io_line_routing u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_pin(in_pin),
        .acq_trigger_wait(acq), .frame_trigger_wait(frame), .exposure_active(expo), .timer_active(tmr),
        .hw_trigger_input(hw_trig), .user_input(user_in), .out_ctrl(out_ctrl));
    ext_equipment u_ext (.level(level), .out_ctrl(out_ctrl), .in_pin(in_pin), .conducting(cond));
    // ==========================================
    // Clock, 25 ns period
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // ==========================================
    // Compare tasks
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] s_v);
        compares++;
        if (s_v !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s_v);
        end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] s_v);
        compares++;
        if (s_v !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s_v);
        end
    endtask
    // ==========================================
    // AXI4-Lite write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
        logic ad, wd;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        // No limit of its own: only the watchdog ends a hang
        do begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk_resp("bresp", er, bresp);
    endtask
    // AXI4-Lite read: rready held until the data is seen
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] dat);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dat = rdata;
        rready <= 1'b0;
        chk_resp("rresp", er, rresp);
    endtask
    // ==========================================
    // Expected output control bits from the bench's own configuration copy
    function automatic logic [3:0] exp_out();
        logic [3:0] r;
        logic b;
        for (int k = 0; k < 4; k++) begin
            case (src_cfg[k])
                io_line_pkg::SRC_ACQ_WAIT: b = acq;
                io_line_pkg::SRC_FRAME_WAIT: b = frame;
                io_line_pkg::SRC_EXPOSURE: b = expo;
                io_line_pkg::SRC_TIMER: b = tmr[k];
                default: b = uval[k];
            endcase
            r[k] = b ^ inv_cfg[k];
        end
        return r;
    endfunction
    // Let a change reach the registered control bits, then compare all four
    task automatic settle();
        repeat (3) @(posedge aclk);
        chk_word("out_ctrl", {28'h0, exp_out()}, {28'h0, cond});
    endtask
    // ==========================================
    // Verdict
    task automatic tally_and_finish();
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog, far beyond the expected thousand or so cycles
    initial begin
        #1000000;
        miscompares++;
        tally_and_finish();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset sources read back per output
        for (o = 0; o < 4; o++) begin
            wr(io_line_pkg::OFF_LINE_SEL, 32'(o + 2), io_line_pkg::RESP_OKAY);
            rd(io_line_pkg::OFF_LINE_SOURCE, io_line_pkg::RESP_OKAY, d);
            chk_word("source", {29'h0, src_cfg[o]}, d);
        end
        // Distinct levels so each reset source shows on its output
        expo <= 1'b1;
        tmr <= 4'h4;
        settle();
        // Every source on every output, without and with inversion
        for (i = 0; i < 2; i++) begin
            for (o = 0; o < 4; o++) begin
                wr(io_line_pkg::OFF_LINE_SEL, 32'(o + 2), io_line_pkg::RESP_OKAY);
                wr(io_line_pkg::OFF_LINE_INV, 32'(i), io_line_pkg::RESP_OKAY);
                inv_cfg[o] = i[0];
                for (s = 0; s < 5; s++) begin
                    wr(io_line_pkg::OFF_LINE_SOURCE, 32'(s), io_line_pkg::RESP_OKAY);
                    src_cfg[o] = 3'(s);
                    for (v = 0; v < 4; v++) begin
                        acq <= v[0];
                        frame <= v[1];
                        expo <= ~v[0];
                        tmr <= v[1] ? ~(4'h1 << o) : (4'h1 << o);
                        settle();
                    end
                end
            end
        end
        // Software values on all outputs, now all user settable
        for (o = 0; o < 4; o++) begin
            wr(io_line_pkg::OFF_USER_SEL, 32'(o), io_line_pkg::RESP_OKAY);
            wr(io_line_pkg::OFF_USER_VAL, {31'h0, ~o[0]}, io_line_pkg::RESP_OKAY);
            uval[o] = ~o[0];
            rd(io_line_pkg::OFF_USER_VAL, io_line_pkg::RESP_OKAY, d);
            chk_word("user_value", {31'h0, ~o[0]}, d);
            settle();
        end
        // Inverter after the software value on output 2
        wr(io_line_pkg::OFF_LINE_SEL, 32'h3, io_line_pkg::RESP_OKAY);
        wr(io_line_pkg::OFF_LINE_INV, 32'h0, io_line_pkg::RESP_OKAY);
        inv_cfg[1] = 1'b0;
        settle();
        wr(io_line_pkg::OFF_LINE_INV, 32'h1, io_line_pkg::RESP_OKAY);
        inv_cfg[1] = 1'b1;
        settle();
        // Inputs: line 1 inverted, every trigger claim with every level
        wr(io_line_pkg::OFF_LINE_SEL, 32'h0, io_line_pkg::RESP_OKAY);
        wr(io_line_pkg::OFF_LINE_INV, 32'h1, io_line_pkg::RESP_OKAY);
        for (m = 0; m < 4; m++) begin
            wr(io_line_pkg::OFF_TRIG_ASSIGN, 32'(m), io_line_pkg::RESP_OKAY);
            for (lv = 0; lv < 4; lv++) begin
                level <= 2'(lv);
                repeat (6) @(posedge aclk);
                st = 2'(lv) ^ 2'h1;
                chk_word("trigger_in", {30'h0, st & 2'(m)}, {30'h0, hw_trig});
                chk_word("user_in", {30'h0, st & ~2'(m)}, {30'h0, user_in});
                rd(io_line_pkg::OFF_STATUS_ALL, io_line_pkg::RESP_OKAY, d);
                chk_word("status_all", {26'h0, exp_out(), st}, d);
                rd(io_line_pkg::OFF_LINE_STATUS, io_line_pkg::RESP_OKAY, d);
                chk_word("line_status", {31'h0, st[0]}, d);
                rd(io_line_pkg::OFF_USER_IN, io_line_pkg::RESP_OKAY, d);
                chk_word("user_word", {30'h0, st & ~2'(m)}, d);
            end
        end
        // Trigger claim and input inverter read back
        rd(io_line_pkg::OFF_TRIG_ASSIGN, io_line_pkg::RESP_OKAY, d);
        chk_word("trig_claim", 32'h3, d);
        rd(io_line_pkg::OFF_LINE_INV, io_line_pkg::RESP_OKAY, d);
        chk_word("in_inverter", 32'h1, d);
        // Unmapped read and read-only write are refused
        rd(8'h24, io_line_pkg::RESP_SLVERR, d);
        chk_word("unmapped", 32'h0, d);
        wr(io_line_pkg::OFF_STATUS_ALL, 32'h0, io_line_pkg::RESP_SLVERR);
        settle();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- hw/io_line_pkg.sv ----
// Package: register map, field layout, reset values and line counts for the camera I/O line block
package io_line_pkg;
    // ==========================================
    // Line counts
    localparam int NUM_IN = 2;   // Physical input lines
    localparam int NUM_OUT = 4;  // Physical output lines
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFF_LINE_SEL = 8'h00;     // Line selector index
    localparam logic [7:0] OFF_LINE_SOURCE = 8'h04;  // Source of selected output
    localparam logic [7:0] OFF_LINE_INV = 8'h08;     // Inverter of selected line
    localparam logic [7:0] OFF_LINE_STATUS = 8'h0c;  // State of selected line
    localparam logic [7:0] OFF_STATUS_ALL = 8'h10;   // All line states
    localparam logic [7:0] OFF_USER_SEL = 8'h14;     // User output selector
    localparam logic [7:0] OFF_USER_VAL = 8'h18;     // User output value
    localparam logic [7:0] OFF_TRIG_ASSIGN = 8'h1c;  // Input lines claimed by trigger
    localparam logic [7:0] OFF_USER_IN = 8'h20;      // User input word
    // ==========================================
    // Line selector coding: 0..1 inputs, 2..5 outputs
    localparam logic [2:0] SEL_FIRST_OUT = 3'h2;
    localparam logic [2:0] SEL_LAST = 3'h5;
    // ==========================================
    // Source codes for output multiplexer
    localparam logic [2:0] SRC_ACQ_WAIT = 3'h0;
    localparam logic [2:0] SRC_FRAME_WAIT = 3'h1;
    localparam logic [2:0] SRC_EXPOSURE = 3'h2;
    localparam logic [2:0] SRC_TIMER = 3'h3;
    localparam logic [2:0] SRC_USER = 3'h4;
    // Reset sources for outputs 1..4 (3 bits each, output 1 lowest)
    localparam logic [11:0] SRC_RESET = {SRC_USER, SRC_TIMER, SRC_FRAME_WAIT, SRC_EXPOSURE};
    // Reset trigger claims: both inputs feed triggers
    localparam logic [1:0] TRIG_RESET = 2'h3;
    // ==========================================
    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hw/io_line_routing.sv ----
// Camera digital I/O line routing with AXI4-Lite register access
//
// Contract
// R1: Trigger-claimed inputs never carry user signals
// R2: Input states readable per line and all
// R3: Per-input invert before internal use
// R4: Four outputs, own source and invert
// R5: Source mux: waits, exposure, timer, user
// R6: User source follows software value
// R7: Reset sources: exposure, frame wait, timer, user
// R8: User value selected by index, readable back
// R9: User value applied before the inverter
// R10: No invert: control bit equals source
// R11: Invert: control bit is complement
// R12: Invert is boolean per selected line
// R13: Software selects line, then writes parameter
// R14: Timer source uses matching numbered timer
// R15: Output control bits registered on clock
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module io_line_routing (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Input pins and internal status sources
    input wire logic [io_line_pkg::NUM_IN-1:0] in_pin,
    input wire logic acq_trigger_wait,
    input wire logic frame_trigger_wait,
    input wire logic exposure_active,
    input wire logic [io_line_pkg::NUM_OUT-1:0] timer_active,
    // Processed inputs towards trigger logic and user
    output logic [io_line_pkg::NUM_IN-1:0] hw_trigger_input,
    output logic [io_line_pkg::NUM_IN-1:0] user_input,
    // Output control bits
    output logic [io_line_pkg::NUM_OUT-1:0] out_ctrl
);
    localparam int NI = io_line_pkg::NUM_IN;
    localparam int NO = io_line_pkg::NUM_OUT;

    // ==========================================
    // Input synchroniser
    logic [NI-1:0] in_meta;  // First stage, read only by second
    logic [NI-1:0] in_sync;  // Second stage

    // Two-flop synchroniser for pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= in_pin;
            in_sync <= in_meta;
        end
    end

    // ==========================================
    // Configuration state
    logic [2:0] line_sel;         // Selected line
    logic [1:0] user_sel;         // Selected user output
    logic [NI-1:0] in_inv;        // Input inverters
    logic [NO-1:0] out_inv;       // Output inverters
    logic [3*NO-1:0] out_src;     // Output sources, 3 bits each
    logic [NO-1:0] user_val;      // User output values
    logic [NI-1:0] trig_assign;   // Inputs claimed by trigger
    logic [2:0] next_line_sel;
    logic [1:0] next_user_sel;
    logic [NI-1:0] next_in_inv;
    logic [NO-1:0] next_out_inv;
    logic [3*NO-1:0] next_out_src;
    logic [NO-1:0] next_user_val;
    logic [NI-1:0] next_trig_assign;

    // ==========================================
    // AXI write channel state
    logic aw_held;                // Address captured
    logic w_held;                 // Data captured
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_awready;           // Address slot free after this edge
    logic next_wready;            // Data slot free after this edge
    logic do_write;               // Both halves present, no response pending

    assign do_write = aw_held && w_held && !bvalid;

    // Write channel and configuration next state
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_line_sel = line_sel;
        next_user_sel = user_sel;
        next_in_inv = in_inv;
        next_out_inv = out_inv;
        next_out_src = out_src;
        next_user_val = user_val;
        next_trig_assign = trig_assign;
        // Accept address and data in either order
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // Response handshake
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Register update, only byte lane 0 holds fields
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = io_line_pkg::RESP_OKAY;
            if (w_strb[0]) begin
                unique case ({aw_addr[7:2], 2'b00})
                    io_line_pkg::OFF_LINE_SEL: begin
                        // Out of range index is kept out
                        if (w_data[2:0] <= io_line_pkg::SEL_LAST) begin
                            next_line_sel = w_data[2:0]; // R13
                        end
                    end
                    io_line_pkg::OFF_LINE_SOURCE: begin
                        // Only outputs have a source; undefined codes ignored
                        if (line_sel >= io_line_pkg::SEL_FIRST_OUT && w_data[2:0] <= io_line_pkg::SRC_USER) begin
                            next_out_src[3*(line_sel-io_line_pkg::SEL_FIRST_OUT) +: 3] = w_data[2:0]; // R4 R13
                        end
                    end
                    io_line_pkg::OFF_LINE_INV: begin
                        if (line_sel >= io_line_pkg::SEL_FIRST_OUT) begin
                            next_out_inv[2'(line_sel-io_line_pkg::SEL_FIRST_OUT)] = w_data[0]; // R12 R13
                        end else begin
                            next_in_inv[line_sel[0]] = w_data[0]; // R3 R13
                        end
                    end
                    io_line_pkg::OFF_USER_SEL: begin
                        next_user_sel = w_data[1:0]; // R8
                    end
                    io_line_pkg::OFF_USER_VAL: begin
                        next_user_val[user_sel] = w_data[0]; // R8
                    end
                    io_line_pkg::OFF_TRIG_ASSIGN: begin
                        next_trig_assign = w_data[NI-1:0]; // R1
                    end
                    default: begin
                        // Read-only or unmapped
                        next_bresp = io_line_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
        // Ready flags are registered copies of the free slots
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
    end

    // Write side registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= io_line_pkg::RESP_OKAY;
            line_sel <= '0;
            user_sel <= '0;
            in_inv <= '0;
            out_inv <= '0;
            out_src <= io_line_pkg::SRC_RESET; // R7
            user_val <= '0;
            trig_assign <= io_line_pkg::TRIG_RESET;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            line_sel <= next_line_sel;
            user_sel <= next_user_sel;
            in_inv <= next_in_inv;
            out_inv <= next_out_inv;
            out_src <= next_out_src;
            user_val <= next_user_val;
            trig_assign <= next_trig_assign;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;

    // ==========================================
    // Input line processing
    logic [NI-1:0] in_state;      // Logical state after inverter
    logic [NI-1:0] next_trig_in;
    logic [NI-1:0] next_user_in;

    assign in_state = in_sync ^ in_inv; // R3

    // Route each input either to trigger logic or to the user
    always_comb begin
        next_trig_in = in_state & trig_assign;
        next_user_in = in_state & ~trig_assign; // R1
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hw_trigger_input <= '0;
            user_input <= '0;
        end else begin
            hw_trigger_input <= next_trig_in;
            user_input <= next_user_in;
        end
    end

    // ==========================================
    // Output multiplexers, one per line
    logic [NO-1:0] next_out_ctrl;

    generate
        for (genvar i = 0; i < NO; i++) begin : g_out
            logic src_level;  // Selected source before inverter
            always_comb begin
                unique case (out_src[3*i +: 3])
                    io_line_pkg::SRC_ACQ_WAIT: src_level = acq_trigger_wait; // R5
                    io_line_pkg::SRC_FRAME_WAIT: src_level = frame_trigger_wait;
                    io_line_pkg::SRC_EXPOSURE: src_level = exposure_active;
                    io_line_pkg::SRC_TIMER: src_level = timer_active[i]; // R14
                    io_line_pkg::SRC_USER: src_level = user_val[i]; // R6 R9
                    default: src_level = 1'b0;
                endcase
                next_out_ctrl[i] = src_level ^ out_inv[i]; // R10 R11
            end
        end
    endgenerate

    // Registered output control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ctrl <= '0;
        end else begin
            out_ctrl <= next_out_ctrl; // R15
        end
    end

    // ==========================================
    // AXI read channel
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_arready;           // Read slot free after this edge

    // Read decode, answered one cycle after the address is taken
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rdata = '0;
            next_rresp = io_line_pkg::RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                io_line_pkg::OFF_LINE_SEL: next_rdata[2:0] = line_sel;
                io_line_pkg::OFF_LINE_SOURCE: begin
                    if (line_sel >= io_line_pkg::SEL_FIRST_OUT) begin
                        next_rdata[2:0] = out_src[3*(line_sel-io_line_pkg::SEL_FIRST_OUT) +: 3];
                    end
                end
                io_line_pkg::OFF_LINE_INV: begin
                    if (line_sel >= io_line_pkg::SEL_FIRST_OUT) begin
                        next_rdata[0] = out_inv[2'(line_sel-io_line_pkg::SEL_FIRST_OUT)];
                    end else begin
                        next_rdata[0] = in_inv[line_sel[0]];
                    end
                end
                io_line_pkg::OFF_LINE_STATUS: begin
                    if (line_sel >= io_line_pkg::SEL_FIRST_OUT) begin
                        next_rdata[0] = out_ctrl[2'(line_sel-io_line_pkg::SEL_FIRST_OUT)];
                    end else begin
                        next_rdata[0] = in_state[line_sel[0]]; // R2
                    end
                end
                io_line_pkg::OFF_STATUS_ALL: next_rdata[NI+NO-1:0] = {out_ctrl, in_state}; // R2
                io_line_pkg::OFF_USER_SEL: next_rdata[1:0] = user_sel;
                io_line_pkg::OFF_USER_VAL: next_rdata[0] = user_val[user_sel]; // R8
                io_line_pkg::OFF_TRIG_ASSIGN: next_rdata[NI-1:0] = trig_assign;
                io_line_pkg::OFF_USER_IN: next_rdata[NI-1:0] = user_input;
                default: next_rresp = io_line_pkg::RESP_SLVERR;
            endcase
        end
        // New address only while no read data is waiting
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= io_line_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            s_axi_arready <= next_arready;
        end
    end

    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    // ==========================================
    // Assertions
    property p_out_follows_src; // R10
        @(posedge aclk) disable iff (!aresetn)
        (out_src[2:0] == io_line_pkg::SRC_USER && !out_inv[0]) |=> out_ctrl[0] == $past(user_val[0]);
    endproperty
    a_out_follows_src: assert property (p_out_follows_src) else $error("Output 1 not equal to user value");

    property p_out_inverted; // R11
        @(posedge aclk) disable iff (!aresetn)
        (out_src[11:9] == io_line_pkg::SRC_USER && out_inv[3]) |=> out_ctrl[3] != $past(user_val[3]);
    endproperty
    a_out_inverted: assert property (p_out_inverted) else $error("Output 4 not inverted");

    property p_user_in_blocked; // R1
        @(posedge aclk) disable iff (!aresetn)
        ##1 ($past(trig_assign) & user_input) == '0;
    endproperty
    a_user_in_blocked: assert property (p_user_in_blocked) else $error("Trigger input leaked to user");

    property p_timer_match; // R14
        @(posedge aclk) disable iff (!aresetn)
        (out_src[8:6] == io_line_pkg::SRC_TIMER && !out_inv[2]) |=> out_ctrl[2] == $past(timer_active[2]);
    endproperty
    a_timer_match: assert property (p_timer_match) else $error("Output 3 not from timer 3");

    property p_exposure; // R5
        @(posedge aclk) disable iff (!aresetn)
        (out_src[5:3] == io_line_pkg::SRC_EXPOSURE && out_inv[1]) |=> out_ctrl[1] == !$past(exposure_active);
    endproperty
    a_exposure: assert property (p_exposure) else $error("Output 2 exposure mismatch");

    property p_reset_src; // R7
        @(posedge aclk) $rose(aresetn) |-> out_src == io_line_pkg::SRC_RESET;
    endproperty
    a_reset_src: assert property (p_reset_src) else $error("Wrong reset sources");

    property p_in_inv; // R3
        @(posedge aclk) disable iff (!aresetn)
        (!trig_assign[0]) |=> user_input[0] == ($past(in_sync[0]) ^ $past(in_inv[0]));
    endproperty
    a_in_inv: assert property (p_in_inv) else $error("Input inverter mismatch");

    property p_user_write; // R8
        @(posedge aclk) disable iff (!aresetn)
        (do_write && w_strb[0] && {aw_addr[7:2], 2'b00} == io_line_pkg::OFF_USER_VAL)
            |=> user_val[$past(user_sel)] == $past(w_data[0]);
    endproperty
    a_user_write: assert property (p_user_write) else $error("User value not stored");
endmodule
`default_nettype wire
